// *** rtl/dmairq_device.sv ***
// Summary of operation
// - Enabled DMA requests from FIFO and trigger
// - Single uses channel A, dual both
// - Single mode floats channel B request
// - Software enables DMA then picks mode
// - Software clears flags before DMA setup
// - Terminal-count clear clears both channels
// - Host reads FIFO per input request
// - Transfer type follows requesting channel
// - Interleaved writes alternate DAC0, DAC1
// - Dual input alternates channel per count
// - Dual output: A to DAC0, B to DAC1
// - Five interrupt sources provided
// - Each source has own enable
// - FIFO read or clear drops conversion flags
// - Acquisition flag holds until conversion clear
// - Update clear drops update flag
// - Trigger sets flag even without waveform
// - Terminal counts kept per channel
// - Count and completion skip general enable
// - Interrupt output can float
// - Update flag says next values welcome
// - Error flag on unserviced update in waveform mode
//
// Added by the designer: the register addresses and strobed register access.
module dmairq_device (
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	dmairq_if.device                           link,
	input  wire logic                          fifo_not_empty_flag,
	input  wire logic                          fifo_half_full_flag,
	input  wire logic [dmairq_pkg::DATA_W-1:0] fifo_data,
	output logic                               fifo_pop,
	input  wire logic                          acq_done,
	input  wire logic                          dac_update_trigger_n,
	output logic [dmairq_pkg::DATA_W-1:0]      dac0_value,
	output logic [dmairq_pkg::DATA_W-1:0]      dac1_value,
	output logic                               dac0_load,
	output logic                               dac1_load
);
	// ***********************************************************
	// State
	// ***********************************************************
	logic [dmairq_pkg::CMD_W-1:0]  cmd_q;
	logic                          trig_s1_q, trig_s2_q, trig_s3_q;
	logic                          conv_ne_q, conv_hf_q, done_q;
	logic                          dac_update_flag_q, dacerr_q, tca_q, tcb_q;
	logic                          in_sel_q, il_q, out_a_q, out_b_q;
	logic [1:0]                    out_cnt_q;
	logic [dmairq_pkg::DATA_W-1:0] stage0_q, stage1_q;
	logic [dmairq_pkg::DATA_W-1:0] rdata_q;
	logic                          dreq_a_q, dreq_b_q, dreq_b_oe_q, irq_q, irq_oe_q;
	logic                          pop_q, load0_q, load1_q;
	logic [dmairq_pkg::DATA_W-1:0] dac0_q, dac1_q;

	// ***********************************************************
	// Decode
	// ***********************************************************
	wire dma_en   = cmd_q[dmairq_pkg::CMD_DMA_EN];
	wire m_in     = cmd_q[dmairq_pkg::CMD_MODE_IN];
	wire m_out    = cmd_q[dmairq_pkg::CMD_MODE_OUT];
	wire m_dual   = cmd_q[dmairq_pkg::CMD_MODE_DUAL];
	wire waveform_generation_enable     = cmd_q[dmairq_pkg::CMD_WAVEFORM_GENERATION_ENABLE];
	wire dack     = link.dack_a | link.dack_b;
	wire reg_wr   = link.bus_wr & ~dack;
	wire reg_rd   = link.bus_rd & ~dack;
	wire wr_cmd   = reg_wr & (link.bus_addr == dmairq_pkg::DEV_CMD);
	wire wr_dac0  = reg_wr & (link.bus_addr == dmairq_pkg::DEV_DAC0);
	wire wr_dac1  = reg_wr & (link.bus_addr == dmairq_pkg::DEV_DAC1);
	wire clr_tc   = reg_wr & (link.bus_addr == dmairq_pkg::DEV_TC_CLR);
	wire clr_up   = reg_wr & (link.bus_addr == dmairq_pkg::DEV_DAC_UPDATE_FLAG_CLR);
	wire clr_conv = reg_wr & (link.bus_addr == dmairq_pkg::DEV_CONV_CLR);
	wire rd_fifo  = (reg_rd & (link.bus_addr == dmairq_pkg::DEV_FIFO)) |
		(dack & link.bus_rd);
	wire trig_fall = trig_s3_q & ~trig_s2_q;
	// Both directions on dual: A carries input, B interleaved output
	wire split_out = m_dual & m_out & ~m_in;
	wire dma_wr    = dack & link.bus_wr;
	wire il_wr     = dma_wr & ~split_out;
	wire to_dac0   = split_out ? link.dack_a : ~il_q;
	wire dac0_wr   = wr_dac0 | (dma_wr & to_dac0);
	wire dac1_wr   = wr_dac1 | (dma_wr & ~to_dac0);
	wire [dmairq_pkg::DATA_W-1:0] wval = link.bus_wdata;

	// ***********************************************************
	// Requests
	// ***********************************************************
	wire in_req  = dma_en & m_in & (fifo_not_empty_flag | fifo_half_full_flag);
	wire out_req = dma_en & m_out & (out_cnt_q != 2'h0);
	wire req_a_d = !m_dual ? (in_req | out_req) :
		m_in ? (in_req & ~in_sel_q) :
		(dma_en & out_a_q);
	wire req_b_d = !m_dual ? 1'b0 :
		(m_in & m_out) ? out_req :
		m_in ? (in_req & in_sel_q) :
		(dma_en & out_b_q);

	// ***********************************************************
	// Interrupt and status
	// ***********************************************************
	wire gen_src = (cmd_q[dmairq_pkg::CMD_NE_IE] & conv_ne_q) |
		(cmd_q[dmairq_pkg::CMD_HF_IE] & conv_hf_q) |
		(cmd_q[dmairq_pkg::CMD_DAC_UPDATE_FLAG_IE] & (dac_update_flag_q | dacerr_q));
	wire irq_d = (cmd_q[dmairq_pkg::CMD_GEN_IE] & gen_src) |
		(cmd_q[dmairq_pkg::CMD_TC_IE] & (tca_q | tcb_q)) |
		(cmd_q[dmairq_pkg::CMD_CMPL_IE] & done_q);
	// Drive the shared line only while the general, count or completion enable is set
	wire irq_oe_d = cmd_q[dmairq_pkg::CMD_GEN_IE] | cmd_q[dmairq_pkg::CMD_TC_IE] |
		cmd_q[dmairq_pkg::CMD_CMPL_IE];
	wire [dmairq_pkg::DATA_W-1:0] status = {7'h00, in_sel_q, irq_q, tcb_q, tca_q,
		dacerr_q, dac_update_flag_q, done_q, conv_hf_q, conv_ne_q};
	wire [dmairq_pkg::DATA_W-1:0] rd_mux =
		(dack | (link.bus_addr == dmairq_pkg::DEV_FIFO)) ? fifo_data :
		(link.bus_addr == dmairq_pkg::DEV_CMD) ? {5'h00, cmd_q} :
		(link.bus_addr == dmairq_pkg::DEV_STATUS) ? status : 16'h0000;

	// ***********************************************************
	// Trigger synchroniser
	// ***********************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			trig_s1_q <= 1'b1;
			trig_s2_q <= 1'b1;
			trig_s3_q <= 1'b1;
		end else begin
			trig_s1_q <= dac_update_trigger_n;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q;
		end
	end

	// ***********************************************************
	// Flags; a set in the clearing cycle wins
	// ***********************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmd_q     <= dmairq_pkg::CMD_RESET;
			conv_ne_q <= 1'b0;
			conv_hf_q <= 1'b0;
			done_q    <= 1'b0;
			dac_update_flag_q   <= 1'b0;
			dacerr_q  <= 1'b0;
			tca_q     <= 1'b0;
			tcb_q     <= 1'b0;
		end else begin
			if (wr_cmd) begin
				cmd_q <= link.bus_wdata[dmairq_pkg::CMD_W-1:0];
			end
			conv_ne_q <= fifo_not_empty_flag | (conv_ne_q & ~(rd_fifo | clr_conv));
			conv_hf_q <= fifo_half_full_flag | (conv_hf_q & ~(rd_fifo | clr_conv));
			done_q    <= acq_done | (done_q & ~clr_conv);
			dac_update_flag_q   <= trig_fall | (dac_update_flag_q & ~clr_up);
			// Edge in waveform mode while previous update still unserviced
			dacerr_q  <= (trig_fall & waveform_generation_enable & dac_update_flag_q) | (dacerr_q & ~clr_up);
			tca_q <= (link.dma_tc & link.dack_a) | (tca_q & ~clr_tc);
			tcb_q <= (link.dma_tc & link.dack_b) | (tcb_q & ~clr_tc);
		end
	end

	// ***********************************************************
	// Channel sequencing
	// ***********************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			in_sel_q  <= 1'b0;
			il_q      <= 1'b0;
			out_a_q   <= 1'b0;
			out_b_q   <= 1'b0;
			out_cnt_q <= 2'h0;
		end else begin
			if (!(dma_en & m_dual & m_in & ~m_out)) begin
				in_sel_q <= 1'b0;
			end else if (link.dma_tc & dack) begin
				in_sel_q <= link.dack_a;
			end
			if (!(dma_en & m_out)) begin
				il_q <= 1'b0;
			end else if (il_wr) begin
				il_q <= ~il_q;
			end
			out_a_q <= (trig_fall & dma_en & split_out) |
				(out_a_q & ~(dma_wr & link.dack_a));
			out_b_q <= (trig_fall & dma_en & split_out) |
				(out_b_q & ~(dma_wr & link.dack_b));
			if (trig_fall & dma_en & m_out & ~split_out) begin
				out_cnt_q <= m_dual ? 2'h1 : dmairq_pkg::OUT_BURST;
			end else if (il_wr & (out_cnt_q != 2'h0)) begin
				out_cnt_q <= out_cnt_q - 2'h1;
			end
		end
	end

	// ***********************************************************
	// DAC staging and load
	// ***********************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage0_q <= 16'h0000;
			stage1_q <= 16'h0000;
			dac0_q   <= 16'h0000;
			dac1_q   <= 16'h0000;
			load0_q  <= 1'b0;
			load1_q  <= 1'b0;
		end else begin
			if (dac0_wr) begin
				stage0_q <= wval;
			end
			if (dac1_wr) begin
				stage1_q <= wval;
			end
			// Waveform mode loads on the edge; otherwise writes go straight out
			load0_q <= waveform_generation_enable ? trig_fall : dac0_wr;
			load1_q <= waveform_generation_enable ? trig_fall : dac1_wr;
			if (waveform_generation_enable & trig_fall) begin
				dac0_q <= stage0_q;
				dac1_q <= stage1_q;
			end else if (!waveform_generation_enable) begin
				dac0_q <= dac0_wr ? wval : dac0_q;
				dac1_q <= dac1_wr ? wval : dac1_q;
			end
		end
	end

	// ***********************************************************
	// Output registers
	// ***********************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q     <= 16'h0000;
			pop_q       <= 1'b0;
			dreq_a_q    <= 1'b0;
			dreq_b_q    <= 1'b0;
			dreq_b_oe_q <= 1'b0;
			irq_q       <= 1'b0;
			irq_oe_q    <= 1'b0;
		end else begin
			rdata_q     <= link.bus_rd ? rd_mux : 16'h0000;
			pop_q       <= rd_fifo;
			dreq_a_q    <= req_a_d;
			dreq_b_q    <= req_b_d;
			dreq_b_oe_q <= m_dual;
			irq_q       <= irq_d;
			irq_oe_q    <= irq_oe_d;
		end
	end

	assign link.bus_rdata = rdata_q;
	assign link.dreq_a    = dreq_a_q;
	assign link.dreq_b    = dreq_b_q;
	assign link.dreq_b_oe = dreq_b_oe_q;
	assign link.irq       = irq_q;
	assign link.irq_oe    = irq_oe_q;
	assign fifo_pop       = pop_q;
	assign dac0_value     = dac0_q;
	assign dac1_value     = dac1_q;
	assign dac0_load      = load0_q;
	assign dac1_load      = load1_q;
endmodule // dmairq_device

// *** rtl/dmairq_host.sv ***
module dmairq_host #(
	parameter int DEPTH = 16
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	dmairq_if.host                             link,
	input  wire logic [dmairq_pkg::ADDR_W-1:0] sw_addr,
	input  wire logic [dmairq_pkg::DATA_W-1:0] sw_wdata,
	input  wire logic                          sw_wr,
	input  wire logic                          sw_rd,
	output logic [dmairq_pkg::DATA_W-1:0]      sw_rdata
);
	localparam int AW = $clog2(DEPTH);

	// ***********************************************************
	// State
	// ***********************************************************
	logic [dmairq_pkg::DATA_W-1:0] mem [0:DEPTH-1];
	logic [dmairq_pkg::ADDR_W-1:0] dev_addr_q, bus_addr_q;
	logic [dmairq_pkg::DATA_W-1:0] dev_wdata_q, dev_rdata_q, bus_wdata_q, sw_rdata_q;
	logic [dmairq_pkg::DATA_W-1:0] cnt_q [2];
	logic [AW-1:0]                 ptr_q [2];
	logic [AW-1:0]                 mem_addr_q, cap_ptr_q;
	logic [3:0]                    chan_q;
	logic                          tca_q, tcb_q, pend_wr_q, pend_rd_q;
	logic                          bus_wr_q, bus_rd_q, dack_a_q, dack_b_q, tc_q;
	logic                          cap_sw_q, cap_mem_q;
	logic [1:0]                    gap_q;

	// ***********************************************************
	// Decode and channel choice
	// ***********************************************************
	wire sel = sw_addr == dmairq_pkg::H_STATUS;
	wire wr_reg_cmd = sw_wr & (sw_addr == dmairq_pkg::H_DEV_CMD);
	wire go_a = link.dreq_a & chan_q[dmairq_pkg::HC_EN_A] & (cnt_q[0] != 16'h0000);
	wire go_b = link.dreq_b_line & chan_q[dmairq_pkg::HC_EN_B] & (cnt_q[1] != 16'h0000);
	wire idle = gap_q == 2'h0;
	wire do_sw = idle & (pend_wr_q | pend_rd_q);
	wire do_dma = idle & ~do_sw & (go_a | go_b);
	wire ch = ~go_a;
	// Channel direction picks FIFO read or DAC write
	wire ch_wr = ch ? chan_q[dmairq_pkg::HC_WR_B] : chan_q[dmairq_pkg::HC_WR_A];
	wire last = cnt_q[ch] == 16'h0001;
	wire [dmairq_pkg::DATA_W-1:0] status = {12'h000, ~idle, tcb_q, tca_q, link.irq_line};
	wire [dmairq_pkg::DATA_W-1:0] rd_mux =
		(sw_addr == dmairq_pkg::H_DEV_ADDR) ? {8'h00, dev_addr_q} :
		(sw_addr == dmairq_pkg::H_DEV_WDATA) ? dev_wdata_q :
		(sw_addr == dmairq_pkg::H_DEV_RDATA) ? dev_rdata_q :
		(sw_addr == dmairq_pkg::H_CNT_A) ? cnt_q[0] :
		(sw_addr == dmairq_pkg::H_CNT_B) ? cnt_q[1] :
		(sw_addr == dmairq_pkg::H_CHAN_CTL) ? {12'h000, chan_q} :
		sel ? status :
		(sw_addr == dmairq_pkg::H_MEM_ADDR) ? {{(dmairq_pkg::DATA_W-AW){1'b0}}, mem_addr_q} :
		(sw_addr == dmairq_pkg::H_MEM_DATA) ? mem[mem_addr_q] : 16'h0000;

	// ***********************************************************
	// Buffer memory; a capture beats a software write
	// ***********************************************************
	always_ff @(posedge core_clk) begin
		if (cap_mem_q) begin
			mem[cap_ptr_q] <= link.bus_rdata;
		end else if (sw_wr & (sw_addr == dmairq_pkg::H_MEM_DATA)) begin
			mem[mem_addr_q] <= sw_wdata;
		end
	end

	// ***********************************************************
	// Software registers
	// ***********************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dev_addr_q  <= 8'h00;
			dev_wdata_q <= 16'h0000;
			dev_rdata_q <= 16'h0000;
			chan_q      <= 4'h0;
			mem_addr_q  <= '0;
			pend_wr_q   <= 1'b0;
			pend_rd_q   <= 1'b0;
			sw_rdata_q  <= 16'h0000;
		end else begin
			if (sw_wr & (sw_addr == dmairq_pkg::H_DEV_ADDR)) dev_addr_q <= sw_addr_w();
			if (sw_wr & (sw_addr == dmairq_pkg::H_DEV_WDATA)) dev_wdata_q <= sw_wdata;
			if (sw_wr & (sw_addr == dmairq_pkg::H_CHAN_CTL)) chan_q <= sw_wdata[3:0];
			if (sw_wr & (sw_addr == dmairq_pkg::H_MEM_ADDR)) mem_addr_q <= sw_wdata[AW-1:0];
			if (cap_sw_q) dev_rdata_q <= link.bus_rdata;
			pend_wr_q <= (wr_reg_cmd & sw_wdata[0]) | (pend_wr_q & ~do_sw);
			pend_rd_q <= (wr_reg_cmd & sw_wdata[1]) | (pend_rd_q & ~(do_sw & ~pend_wr_q));
			sw_rdata_q <= sw_rd ? rd_mux : 16'h0000;
		end
	end

	function automatic logic [dmairq_pkg::ADDR_W-1:0] sw_addr_w();
		return sw_wdata[dmairq_pkg::ADDR_W-1:0];
	endfunction

	// ***********************************************************
	// Transfer engine
	// ***********************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q     <= '{16'h0000, 16'h0000};
			ptr_q     <= '{'0, '0};
			gap_q     <= 2'h0;
			bus_addr_q <= 8'h00;
			bus_wdata_q <= 16'h0000;
			bus_wr_q  <= 1'b0;
			bus_rd_q  <= 1'b0;
			dack_a_q  <= 1'b0;
			dack_b_q  <= 1'b0;
			tc_q      <= 1'b0;
			cap_sw_q  <= 1'b0;
			cap_mem_q <= 1'b0;
			cap_ptr_q <= '0;
			tca_q     <= 1'b0;
			tcb_q     <= 1'b0;
		end else begin
			bus_wr_q  <= do_sw ? pend_wr_q : (do_dma & ch_wr);
			bus_rd_q  <= do_sw ? ~pend_wr_q : (do_dma & ~ch_wr);
			dack_a_q  <= do_dma & ~ch;
			dack_b_q  <= do_dma & ch;
			tc_q      <= do_dma & last;
			// Read data stand only in the cycle after the device takes the read
			cap_sw_q  <= bus_rd_q & ~(dack_a_q | dack_b_q);
			cap_mem_q <= bus_rd_q & (dack_a_q | dack_b_q);
			if (do_dma) begin
				cap_ptr_q <= ptr_q[ch];
			end
			bus_addr_q <= do_sw ? dev_addr_q : 8'h00;
			bus_wdata_q <= do_sw ? dev_wdata_q : mem[ptr_q[ch]];
			// Hold off until the device's request reflects this transfer
			gap_q <= (do_sw | do_dma) ? dmairq_pkg::GAP_CYCLES : (idle ? 2'h0 : gap_q - 2'h1);
			tca_q <= (do_dma & last & ~ch) | (tca_q & ~(sw_wr & sel & sw_wdata[1]));
			tcb_q <= (do_dma & last & ch) | (tcb_q & ~(sw_wr & sel & sw_wdata[2]));
			if (do_dma) begin
				cnt_q[ch] <= cnt_q[ch] - 16'h0001;
				ptr_q[ch] <= ptr_q[ch] + 1'b1;
			end
			if (sw_wr & (sw_addr == dmairq_pkg::H_CNT_A)) begin
				cnt_q[0] <= sw_wdata;
				ptr_q[0] <= '0;
			end
			if (sw_wr & (sw_addr == dmairq_pkg::H_CNT_B)) begin
				cnt_q[1] <= sw_wdata;
				ptr_q[1] <= AW'(DEPTH / 2);
			end
		end
	end

	assign link.bus_addr  = bus_addr_q;
	assign link.bus_wdata = bus_wdata_q;
	assign link.bus_wr    = bus_wr_q;
	assign link.bus_rd    = bus_rd_q;
	assign link.dack_a    = dack_a_q;
	assign link.dack_b    = dack_b_q;
	assign link.dma_tc    = tc_q;
	assign sw_rdata       = sw_rdata_q;
endmodule // dmairq_host

// *** rtl/dmairq_if.sv ***
interface dmairq_if;
	logic [dmairq_pkg::ADDR_W-1:0] bus_addr;
	logic [dmairq_pkg::DATA_W-1:0] bus_wdata;
	logic                          bus_wr;
	logic                          bus_rd;
	logic [dmairq_pkg::DATA_W-1:0] bus_rdata;
	logic                          dack_a;
	logic                          dack_b;
	logic                          dma_tc;
	logic                          dreq_a;
	logic                          dreq_b;
	logic                          dreq_b_oe;
	logic                          irq;
	logic                          irq_oe;
	logic                          dreq_b_line;
	logic                          irq_line;

	// Undriven lines fall low, as with a pull-down
	assign dreq_b_line = dreq_b_oe ? dreq_b : 1'b0;
	assign irq_line    = irq_oe ? irq : 1'b0;

	modport device (
		input  bus_addr, bus_wdata, bus_wr, bus_rd, dack_a, dack_b, dma_tc,
		output bus_rdata, dreq_a, dreq_b, dreq_b_oe, irq, irq_oe
	);
	modport host (
		output bus_addr, bus_wdata, bus_wr, bus_rd, dack_a, dack_b, dma_tc,
		input  bus_rdata, dreq_a, dreq_b_line, irq_line
	);
endinterface

// *** rtl/dmairq_pkg.sv ***
package dmairq_pkg;
	// ***********************************************************
	// Widths
	// ***********************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int CMD_W  = 11;

	// ***********************************************************
	// Device register offsets
	// ***********************************************************
	localparam logic [7:0] DEV_CMD       = 8'h00;
	localparam logic [7:0] DEV_STATUS    = 8'h04;
	localparam logic [7:0] DEV_FIFO      = 8'h08;
	localparam logic [7:0] DEV_DAC0      = 8'h0c;
	localparam logic [7:0] DEV_DAC1      = 8'h10;
	localparam logic [7:0] DEV_TC_CLR    = 8'h14;
	localparam logic [7:0] DEV_DAC_UPDATE_FLAG_CLR = 8'h18;
	localparam logic [7:0] DEV_CONV_CLR  = 8'h1c;

	// ***********************************************************
	// Command register fields
	// ***********************************************************
	localparam int CMD_DMA_EN   = 0;
	localparam int CMD_MODE_IN  = 1;
	localparam int CMD_MODE_OUT = 2;
	localparam int CMD_MODE_DUAL = 3;
	localparam int CMD_WAVEFORM_GENERATION_ENABLE     = 4;
	localparam int CMD_GEN_IE   = 5;
	localparam int CMD_TC_IE    = 6;
	localparam int CMD_CMPL_IE  = 7;
	localparam int CMD_NE_IE    = 8;
	localparam int CMD_HF_IE    = 9;
	localparam int CMD_DAC_UPDATE_FLAG_IE = 10;
	localparam logic [CMD_W-1:0] CMD_RESET = 11'h000;

	// ***********************************************************
	// Status register fields
	// ***********************************************************
	localparam int ST_NE     = 0;
	localparam int ST_HF     = 1;
	localparam int ST_DONE   = 2;
	localparam int ST_DAC_UPDATE_FLAG  = 3;
	localparam int ST_DACERR = 4;
	localparam int ST_TCA    = 5;
	localparam int ST_TCB    = 6;
	localparam int ST_IRQ    = 7;
	localparam int ST_INSEL  = 8;

	// ***********************************************************
	// Timing and counts
	// ***********************************************************
	localparam logic [1:0] OUT_BURST  = 2'h2;
	localparam logic [1:0] GAP_CYCLES = 2'h2;

	// ***********************************************************
	// Host register offsets and fields
	// ***********************************************************
	localparam logic [7:0] H_DEV_ADDR  = 8'h00;
	localparam logic [7:0] H_DEV_WDATA = 8'h04;
	localparam logic [7:0] H_DEV_CMD   = 8'h08;
	localparam logic [7:0] H_DEV_RDATA = 8'h0c;
	localparam logic [7:0] H_CNT_A     = 8'h10;
	localparam logic [7:0] H_CNT_B     = 8'h14;
	localparam logic [7:0] H_CHAN_CTL  = 8'h18;
	localparam logic [7:0] H_STATUS    = 8'h1c;
	localparam logic [7:0] H_MEM_ADDR  = 8'h20;
	localparam logic [7:0] H_MEM_DATA  = 8'h24;
	localparam int HC_EN_A = 0;
	localparam int HC_WR_A = 1;
	localparam int HC_EN_B = 2;
	localparam int HC_WR_B = 3;
	localparam int HS_IRQ  = 0;
	localparam int HS_TCA  = 1;
	localparam int HS_TCB  = 2;
	localparam int HS_BUSY = 3;
endpackage

// *** test/dmairq_monitor.sv ***
module dmairq_monitor (
	input wire logic                          core_clk,
	input wire logic                          rst,
	input wire logic [dmairq_pkg::ADDR_W-1:0] bus_addr,
	input wire logic [dmairq_pkg::DATA_W-1:0] bus_wdata,
	input wire logic                          bus_wr,
	input wire logic                          bus_rd,
	input wire logic [dmairq_pkg::DATA_W-1:0] bus_rdata,
	input wire logic                          dack_a,
	input wire logic                          dack_b,
	input wire logic                          dma_tc,
	input wire logic                          dreq_a,
	input wire logic                          dreq_b,
	input wire logic                          dreq_b_oe,
	input wire logic                          irq,
	input wire logic                          irq_oe
);
	// ********
	// Shadow of command and count flags
	// ********
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [10:0] cmd_q;
	logic [1:0]  tc_q;
	wire idle_acc = !dack_a && !dack_b;
	wire cmd_wr   = bus_wr && idle_acc && bus_addr == dmairq_pkg::DEV_CMD;
	wire tc_clr   = bus_wr && idle_acc && bus_addr == dmairq_pkg::DEV_TC_CLR;
	wire st_rd    = bus_rd && idle_acc && bus_addr == dmairq_pkg::DEV_STATUS;
	wire dual_in  = cmd_q[3:0] == 4'hb;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmd_q <= 11'h000;
			tc_q  <= 2'h0;
		end else begin
			cmd_q <= cmd_wr ? bus_wdata[10:0] : cmd_q;
			// Set beats clear, as in the device
			tc_q  <= {dma_tc && dack_b, dma_tc && dack_a} | (tc_clr ? 2'h0 : tc_q);
		end
	end
	sequence tc_on_a; dual_in && dack_a && dma_tc; endsequence
	sequence tc_on_b; dual_in && dack_b && dma_tc; endsequence
	chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
		else $error("read data outside its slot");
	chk_req_gated: assert property (!cmd_q[0] && !$past(cmd_q[0]) && !$past(cmd_q[0], 2)
		|-> !dreq_a && !dreq_b) else $error("request while disabled");
	chk_tc_a_switch: assert property (tc_on_a |-> ##2 !dreq_a)
		else $error("channel A kept after count");
	chk_tc_b_switch: assert property (tc_on_b |-> ##2 !dreq_b)
		else $error("channel B kept after count");
	chk_tc_status: assert property (st_rd |=> bus_rdata[6:5] == $past(tc_q))
		else $error("count flags wrong");
	chk_tc_irq: assert property (cmd_q[6] && tc_q != 2'h0 |=> irq)
		else $error("count irq missing");
	chk_irq_quiet: assert property (cmd_q[7:5] == 3'h0 |=> !irq)
		else $error("irq with no enable");
	chk_irq_oe: assert property (cmd_q == $past(cmd_q) |-> irq_oe == (|cmd_q[7:5]))
		else $error("irq enable wrong");
	chk_b_float: assert property (cmd_q == $past(cmd_q) |-> dreq_b_oe == cmd_q[3])
		else $error("channel B drive wrong");
endmodule // dmairq_monitor

// *** test/dmairq_test.sv ***
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR %0t got %h want %h", $time, a, b); end end
module dmairq_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 0;
	logic        rst = 1;
	logic [7:0]  sw_addr = 8'h00;
	logic [15:0] sw_wdata = 16'h0000;
	logic        sw_wr = 0;
	logic        sw_rd = 0;
	logic        ne = 0;
	logic        hf = 0;
	logic        pop, ld0, ld1;
	int          pops = 0;
	int          loads = 0;
	logic        done_p = 0;
	logic        trig_n = 1;
	logic [15:0] sw_rdata, d, dac0, dac1;
	int          err_count = 0;
	int          num_checks = 0;
	dmairq_if link ();
	dmairq_device dmairq_device_inst (.core_clk(core_clk), .rst(rst), .link(link),
		.fifo_not_empty_flag(ne), .fifo_half_full_flag(hf), .fifo_data(16'h1234), .fifo_pop(pop),
		.acq_done(done_p), .dac_update_trigger_n(trig_n), .dac0_value(dac0), .dac1_value(dac1),
		.dac0_load(ld0), .dac1_load(ld1));
	dmairq_host dmairq_host_inst (.core_clk(core_clk), .rst(rst), .link(link), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
	dmairq_monitor dmairq_monitor_inst (.core_clk(core_clk), .rst(rst), .bus_addr(link.bus_addr),
		.bus_wdata(link.bus_wdata), .bus_wr(link.bus_wr), .bus_rd(link.bus_rd),
		.bus_rdata(link.bus_rdata), .dack_a(link.dack_a), .dack_b(link.dack_b),
		.dma_tc(link.dma_tc), .dreq_a(link.dreq_a), .dreq_b(link.dreq_b),
		.dreq_b_oe(link.dreq_b_oe), .irq(link.irq), .irq_oe(link.irq_oe));
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		pops <= pops + int'(pop);
		loads <= loads + int'(ld0) + int'(ld1);
	end
	task automatic sw_w(input logic [7:0] a, input logic [15:0] v);
		@(posedge core_clk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_r(input logic [7:0] a);
		@(posedge core_clk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
		@(negedge core_clk);
		d = sw_rdata;
	endtask
	// Fixed waits: the host issues one cycle after the command
	task automatic dev_w(input logic [7:0] a, input logic [15:0] v);
		sw_w(dmairq_pkg::H_DEV_ADDR, {8'h00, a});
		sw_w(dmairq_pkg::H_DEV_WDATA, v);
		sw_w(dmairq_pkg::H_DEV_CMD, 16'h0001);
		repeat (3) @(posedge core_clk);
	endtask
	task automatic dev_r(input logic [7:0] a);
		sw_w(dmairq_pkg::H_DEV_ADDR, {8'h00, a});
		sw_w(dmairq_pkg::H_DEV_CMD, 16'h0002);
		repeat (4) @(posedge core_clk);
		sw_r(dmairq_pkg::H_DEV_RDATA);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge core_clk);
		err_count++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		dev_w(dmairq_pkg::DEV_CMD, 16'h004b);
		dev_w(dmairq_pkg::DEV_TC_CLR, 16'h0000);
		dev_w(dmairq_pkg::DEV_DAC_UPDATE_FLAG_CLR, 16'h0000);
		dev_w(dmairq_pkg::DEV_CONV_CLR, 16'h0000);
		sw_w(dmairq_pkg::H_CNT_A, 16'h0001);
		sw_w(dmairq_pkg::H_CNT_B, 16'h0001);
		sw_w(dmairq_pkg::H_CHAN_CTL, 16'h0005);
		ne <= 1'b1;
		repeat (40) @(posedge core_clk);
		dev_r(dmairq_pkg::DEV_STATUS);
		`CHK(d[8:5], 4'h7)
		sw_r(dmairq_pkg::H_STATUS);
		`CHK(d[2:0], 3'h7)
		sw_w(dmairq_pkg::H_MEM_ADDR, 16'h0008);
		sw_r(dmairq_pkg::H_MEM_DATA);
		`CHK(d, 16'h1234)
		`CHK(pops, 2)
		dev_w(dmairq_pkg::DEV_TC_CLR, 16'h0000);
		dev_r(dmairq_pkg::DEV_STATUS);
		`CHK(d[6:5], 2'h0)
		$display("test dual input done");
		ne <= 1'b0;
		sw_w(dmairq_pkg::H_CHAN_CTL, 16'h0000);
		dev_w(dmairq_pkg::DEV_CMD, 16'h0005);
		sw_w(dmairq_pkg::H_MEM_ADDR, 16'h0000);
		sw_w(dmairq_pkg::H_MEM_DATA, 16'haaaa);
		sw_w(dmairq_pkg::H_MEM_ADDR, 16'h0001);
		sw_w(dmairq_pkg::H_MEM_DATA, 16'hbbbb);
		sw_w(dmairq_pkg::H_CNT_A, 16'h0002);
		sw_w(dmairq_pkg::H_CHAN_CTL, 16'h0003);
		trig_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		trig_n <= 1'b1;
		repeat (40) @(posedge core_clk);
		`CHK({dac0, dac1}, 32'haaaabbbb)
		dev_r(dmairq_pkg::DEV_STATUS);
		`CHK(d[3], 1'b1)
		dev_w(dmairq_pkg::DEV_DAC_UPDATE_FLAG_CLR, 16'h0000);
		dev_r(dmairq_pkg::DEV_STATUS);
		`CHK(d[4:3], 2'h0)
		$display("test interleave done");
		sw_w(dmairq_pkg::H_MEM_ADDR, 16'h0000);
		sw_w(dmairq_pkg::H_MEM_DATA, 16'hcccc);
		sw_w(dmairq_pkg::H_MEM_ADDR, 16'h0008);
		sw_w(dmairq_pkg::H_MEM_DATA, 16'hdddd);
		sw_w(dmairq_pkg::H_CNT_A, 16'h0001);
		sw_w(dmairq_pkg::H_CNT_B, 16'h0001);
		sw_w(dmairq_pkg::H_CHAN_CTL, 16'h000f);
		dev_w(dmairq_pkg::DEV_CMD, 16'h000d);
		trig_n <= 1'b0;
		repeat (4) @(posedge core_clk);
		trig_n <= 1'b1;
		repeat (40) @(posedge core_clk);
		`CHK({dac0, dac1}, 32'hccccdddd)
		`CHK(loads, 4)
		$display("test dual output done");
		dev_w(dmairq_pkg::DEV_CMD, 16'h01a0);
		done_p <= 1'b1;
		@(posedge core_clk) done_p <= 1'b0;
		{ne, hf} <= 2'h3;
		repeat (4) @(posedge core_clk);
		sw_r(dmairq_pkg::H_STATUS);
		`CHK(d[0], 1'b1)
		dev_r(dmairq_pkg::DEV_STATUS);
		`CHK(d[2:0], 3'h7)
		@(posedge core_clk) {ne, hf} <= 2'h0;
		dev_r(dmairq_pkg::DEV_FIFO);
		dev_r(dmairq_pkg::DEV_STATUS);
		`CHK(d[2:0], 3'h4)
		`CHK(pops, 3)
		dev_w(dmairq_pkg::DEV_CONV_CLR, 16'h0000);
		dev_r(dmairq_pkg::DEV_STATUS);
		`CHK(d[2:0], 3'h0)
		sw_r(dmairq_pkg::H_STATUS);
		`CHK(d[0], 1'b0)
		$display("test interrupts done");
		report_and_stop();
	end
endmodule // dmairq_test
